/* src/dre_consts.svh */
// constants for the debug request entry block: timing and reset values
// assumes a single processor clock; included by bare name
`ifndef DRE_CONSTS_SVH
`define DRE_CONSTS_SVH

// =====================================
// timing
`define DRE_CLK_PERIOD_NS 8
`define DRE_ACK_NS        16
// least time, so round up to whole cycles
`define DRE_ACK_CYC       ((`DRE_ACK_NS + `DRE_CLK_PERIOD_NS - 1) / `DRE_CLK_PERIOD_NS)

// =====================================
// widths and reset levels
`define DRE_WORD_BITS     24
`define DRE_PIPE_BITS     24
`define DRE_SYNC_RST      3'b001
`define DRE_ACK_CNT_BITS  4

`endif

/* src/dre_pkg.sv */
// types for the debug request entry block
// assumes dre_consts.svh supplies the numeric constants
package dre_pkg;

   // =====================================
   // controller states
   typedef enum logic [2:0] {
      DRE_RUN     = 3'b000,
      DRE_HALTING = 3'b001,
      DRE_ACK     = 3'b010,
      DRE_DEBUG   = 3'b011,
      DRE_PRST    = 3'b100
   } dre_state_t;

endpackage

/* src/dre_sync.sv */
// two flip-flop synchroniser for a group of asynchronous pins
// assumes inputs are independent levels; reset value is a constant
`timescale 1ns/1ps

module dre_sync #(
   parameter int         W       = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  wire logic         mclk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] meta_next;
   logic [W-1:0] sync_reg;
   logic [W-1:0] sync_next;

   // the first stage feeds the second stage only
   always_comb begin
      meta_next = async_i;
      sync_next = meta_reg;
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_reg <= RST_VAL;
         sync_reg <= RST_VAL;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_o = sync_reg;

endmodule // dre_sync

/* src/dre_entry.sv */
// debug request entry: halts the core, saves the pipeline, acknowledges
// on the serial output and shifts serial words while in debug mode.
// assumes the core reports instruction completion and low power state
// on mclk_i; pins arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "dre_consts.svh"

module dre_entry #(
   parameter int WORD_BITS = `DRE_WORD_BITS,
   parameter int PIPE_BITS = `DRE_PIPE_BITS
) (
   input  wire logic                 mclk_i,
   input  wire logic                 sys_rst_i,
   input  wire logic                 debug_request_n_i,
   input  wire logic                 debug_serial_clock_i,
   input  wire logic                 debug_serial_in_i,
   input  wire logic                 core_instr_done_i,
   input  wire logic                 core_low_power_i,
   input  wire logic [PIPE_BITS-1:0] pipe_state_i,
   input  wire logic                 cmd_ack_i,
   input  wire logic                 exit_debug_i,
   input  wire logic                 tx_load_i,
   input  wire logic [WORD_BITS-1:0] tx_word_i,
   output logic                      core_halt_o,
   output logic                      core_wake_o,
   output dre_pkg::dre_state_t       state_o,
   output logic                      debug_mode_o,
   output logic [PIPE_BITS-1:0]      pipe_saved_o,
   output logic                      port_reset_o,
   output logic [WORD_BITS-1:0]      rx_word_o,
   output logic                      rx_valid_o,
   output logic                      tx_busy_o,
   output logic                      debug_serial_out_o
);
   import dre_pkg::*;

   localparam int CW = $clog2(WORD_BITS + 1);
   localparam logic [`DRE_ACK_CNT_BITS-1:0] ACK_LEN = `DRE_ACK_CNT_BITS'(`DRE_ACK_CYC);
   localparam logic [CW-1:0] WORD_LAST = CW'(WORD_BITS - 1);
   localparam logic [CW-1:0] WORD_CNT  = CW'(WORD_BITS);

   // =====================================
   // pin synchronisation
   logic [2:0] pins_sync;

   dre_sync #(
      .W       (3),
      .RST_VAL (`DRE_SYNC_RST)
   ) u_sync (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   ({debug_serial_in_i, debug_serial_clock_i, debug_request_n_i}),
      .sync_o    (pins_sync)
   );

   logic dr_n_s;
   logic sck_s;
   logic sdi_s;
   assign dr_n_s = pins_sync[0];
   assign sck_s  = pins_sync[1];
   assign sdi_s  = pins_sync[2];

   // =====================================
   // state
   dre_state_t                    state_reg,    state_next;
   logic                          dr_n_d_reg,   dr_n_d_next;
   logic                          sck_d_reg,    sck_d_next;
   logic [`DRE_ACK_CNT_BITS-1:0]  ack_cnt_reg,  ack_cnt_next;
   logic [PIPE_BITS-1:0]          pipe_reg,     pipe_next;
   logic                          halt_reg,     halt_next;
   logic                          wake_reg,     wake_next;
   logic                          prst_reg,     prst_next;
   logic [WORD_BITS-1:0]          rx_sh_reg,    rx_sh_next;
   logic [CW-1:0]                 rx_cnt_reg,   rx_cnt_next;
   logic [WORD_BITS-1:0]          rx_word_reg,  rx_word_next;
   logic                          rx_vld_reg,   rx_vld_next;
   logic [WORD_BITS-1:0]          tx_sh_reg,    tx_sh_next;
   logic [CW-1:0]                 tx_cnt_reg,   tx_cnt_next;
   logic                          tx_bit_reg,   tx_bit_next;
   logic                          dso_reg,      dso_next;

   logic dr_assert;
   logic sck_fall;
   logic sck_rise;
   logic in_debug;
   logic ack_start;

   // edges taken from the second synchroniser stage only
   assign dr_assert = dr_n_d_reg & ~dr_n_s;
   assign sck_fall  = sck_d_reg & ~sck_s;
   assign sck_rise  = ~sck_d_reg & sck_s;
   assign in_debug  = (state_reg == DRE_DEBUG);

   // =====================================
   // control state machine and acknowledge timing
   always_comb begin
      state_next   = state_reg;
      dr_n_d_next  = dr_n_s;
      sck_d_next   = sck_s;
      ack_cnt_next = (ack_cnt_reg != '0) ? ack_cnt_reg - 1'b1 : ack_cnt_reg;
      pipe_next    = pipe_reg;
      halt_next    = halt_reg;
      wake_next    = 1'b0;
      prst_next    = 1'b0;
      ack_start    = 1'b0;
      unique case (state_reg)
         DRE_RUN: begin
            if (dr_assert) begin
               halt_next = 1'b1;
               if (core_low_power_i) begin
                  wake_next  = 1'b1;
                  pipe_next  = pipe_state_i;
                  ack_start  = 1'b1;
                  state_next = DRE_ACK;
               end else begin
                  state_next = DRE_HALTING;
               end
            end
         end
         DRE_HALTING: begin
            if (core_instr_done_i) begin
               pipe_next  = pipe_state_i;
               ack_start  = 1'b1;
               state_next = DRE_ACK;
            end
         end
         DRE_ACK: begin
            if (ack_cnt_reg == `DRE_ACK_CNT_BITS'(1)) begin
               state_next = DRE_DEBUG;
            end
         end
         DRE_DEBUG: begin
            if (dr_assert) begin
               prst_next  = 1'b1;
               ack_start  = 1'b1;
               state_next = DRE_PRST;
            end else if (exit_debug_i) begin
               halt_next  = 1'b0;
               state_next = DRE_RUN;
            end else if (cmd_ack_i) begin
               ack_start = 1'b1;
            end
         end
         DRE_PRST: begin
            if (dr_n_s && ack_cnt_reg == '0) begin
               state_next = DRE_DEBUG;
            end
         end
         default: begin
            state_next = DRE_RUN;
            halt_next  = 1'b0;
         end
      endcase
      if (ack_start) begin
         ack_cnt_next = ACK_LEN;
      end
   end

   // =====================================
   // serial shifting and output pin
   always_comb begin
      rx_sh_next   = rx_sh_reg;
      rx_cnt_next  = rx_cnt_reg;
      rx_word_next = rx_word_reg;
      rx_vld_next  = 1'b0;
      tx_sh_next   = tx_sh_reg;
      tx_cnt_next  = tx_cnt_reg;
      tx_bit_next  = tx_bit_reg;
      if (prst_reg || !in_debug) begin
         rx_cnt_next = '0;
         tx_cnt_next = '0;
         tx_bit_next = 1'b1;
      end else begin
         // held request blocks input, covering a late release
         if (sck_fall && dr_n_s) begin
            rx_sh_next = {rx_sh_reg[WORD_BITS-2:0], sdi_s};
            if (rx_cnt_reg == WORD_LAST) begin
               rx_word_next = {rx_sh_reg[WORD_BITS-2:0], sdi_s};
               rx_vld_next  = 1'b1;
               rx_cnt_next  = '0;
            end else begin
               rx_cnt_next = rx_cnt_reg + 1'b1;
            end
         end
         if (tx_load_i && tx_cnt_reg == '0) begin
            tx_sh_next  = tx_word_i;
            tx_cnt_next = WORD_CNT;
         end else if (sck_rise && tx_cnt_reg != '0) begin
            // launch on rising edge, msb first
            tx_bit_next = tx_sh_reg[WORD_BITS-1];
            tx_sh_next  = {tx_sh_reg[WORD_BITS-2:0], 1'b0};
            tx_cnt_next = tx_cnt_reg - 1'b1;
         end
      end
      // acknowledge low overrides data; idle high outside debug, last bit held in debug
      // keyed on the next count so the pulse lasts exactly the ack length
      if (ack_cnt_next != '0) begin
         dso_next = 1'b0;
      end else if (in_debug && (tx_cnt_reg != '0 || !tx_bit_reg)) begin
         dso_next = tx_bit_next;
      end else begin
         dso_next = 1'b1;
      end
   end

   // =====================================
   // registers; reset leaves the serial output high
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg   <= DRE_RUN;
         dr_n_d_reg  <= 1'b1;
         sck_d_reg   <= 1'b0;
         ack_cnt_reg <= '0;
         pipe_reg    <= '0;
         halt_reg    <= 1'b0;
         wake_reg    <= 1'b0;
         prst_reg    <= 1'b0;
         rx_sh_reg   <= '0;
         rx_cnt_reg  <= '0;
         rx_word_reg <= '0;
         rx_vld_reg  <= 1'b0;
         tx_sh_reg   <= '0;
         tx_cnt_reg  <= '0;
         tx_bit_reg  <= 1'b1;
         dso_reg     <= 1'b1;
      end else begin
         state_reg   <= state_next;
         dr_n_d_reg  <= dr_n_d_next;
         sck_d_reg   <= sck_d_next;
         ack_cnt_reg <= ack_cnt_next;
         pipe_reg    <= pipe_next;
         halt_reg    <= halt_next;
         wake_reg    <= wake_next;
         prst_reg    <= prst_next;
         rx_sh_reg   <= rx_sh_next;
         rx_cnt_reg  <= rx_cnt_next;
         rx_word_reg <= rx_word_next;
         rx_vld_reg  <= rx_vld_next;
         tx_sh_reg   <= tx_sh_next;
         tx_cnt_reg  <= tx_cnt_next;
         tx_bit_reg  <= tx_bit_next;
         dso_reg     <= dso_next;
      end
   end

   // outputs from flops; debug_mode_o and tx_busy_o are decoded from state_reg and tx_cnt_reg
   assign core_halt_o        = halt_reg;
   assign core_wake_o        = wake_reg;
   assign state_o            = state_reg;
   assign debug_mode_o       = (state_reg == DRE_DEBUG) || (state_reg == DRE_PRST);
   assign pipe_saved_o       = pipe_reg;
   assign port_reset_o       = prst_reg;
   assign rx_word_o          = rx_word_reg;
   assign rx_valid_o         = rx_vld_reg;
   assign tx_busy_o          = (tx_cnt_reg != '0);
   assign debug_serial_out_o = dso_reg;

endmodule // dre_entry

/* test/dre_entry_assertions.sv */
// checker for the debug request entry block, bound to its top ports
// assumes one processor clock and an active high asynchronous reset
`timescale 1ns/1ps

// ==========
// checker
module dre_entry_assertions
   import dre_pkg::*;
#(
   parameter int PIPE_BITS = 24
) (
   input wire logic                 mclk_i,
   input wire logic                 sys_rst_i,
   input wire logic                 debug_request_n_i,
   input wire logic                 core_instr_done_i,
   input wire logic                 core_low_power_i,
   input wire logic [PIPE_BITS-1:0] pipe_state_i,
   input wire logic                 tx_load_i,
   input wire logic                 core_halt_o,
   input wire logic                 core_wake_o,
   input wire dre_pkg::dre_state_t  state_o,
   input wire logic [PIPE_BITS-1:0] pipe_saved_o,
   input wire logic                 port_reset_o,
   input wire logic                 rx_valid_o,
   input wire logic                 tx_busy_o,
   input wire logic                 debug_serial_out_o
);
   import dre_pkg::*;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);

   // halt follows the synchronised request by a few edges only
   a_halt_req: assert property (
      state_o == DRE_RUN && !core_low_power_i && $fell(debug_request_n_i)
      |-> ##[2:5] core_halt_o) else $error("halt missing after request");
   a_ack_len: assert property (
      state_o == DRE_HALTING && core_instr_done_i
      |=> !debug_serial_out_o [*2] ##1 debug_serial_out_o && state_o == DRE_DEBUG)
      else $error("entry acknowledge wrong");
   a_pipe_save: assert property (
      state_o == DRE_HALTING && core_instr_done_i
      |=> pipe_saved_o == $past(pipe_state_i)) else $error("pipeline not saved");
   a_prst_ack: assert property (
      port_reset_o |-> $past(state_o) == DRE_DEBUG && !debug_serial_out_o ##1 !port_reset_o)
      else $error("port reset wrong");
   a_wake_ack: assert property (
      core_wake_o |-> $past(state_o) == DRE_RUN && !debug_serial_out_o ##1 !core_wake_o)
      else $error("wake wrong");
   a_run_idle: assert property (
      state_o == DRE_RUN |-> debug_serial_out_o) else $error("serial out low when idle");
   a_rx_mode: assert property (
      rx_valid_o |-> $past(state_o) == DRE_DEBUG ##1 !rx_valid_o)
      else $error("word received outside debug");
   a_tx_take: assert property (
      state_o == DRE_DEBUG && tx_load_i && !tx_busy_o |=> tx_busy_o)
      else $error("load not taken");

   c_prst: cover property (port_reset_o);
   c_wake: cover property (core_wake_o);
   c_rx: cover property (rx_valid_o);
endmodule // dre_entry_assertions

bind dre_entry dre_entry_assertions #(.PIPE_BITS(PIPE_BITS)) u_chk (
   .mclk_i, .sys_rst_i, .debug_request_n_i, .core_instr_done_i, .core_low_power_i,
   .pipe_state_i, .tx_load_i, .core_halt_o, .core_wake_o, .state_o, .pipe_saved_o,
   .port_reset_o, .rx_valid_o, .tx_busy_o, .debug_serial_out_o);

/* test/dre_ctrl_model.sv */
// external debug controller: request pin and 80 ns serial clock
// assumes the bench calls its tasks; serial lines idle low (pull-down)
`timescale 1ns/1ps

// ==========
// controller model
module dre_ctrl_model (
   input  wire logic mclk_i,
   input  wire logic dso_i,
   output logic      req_n_o,
   output logic      sck_o,
   output logic      sdi_o
);
   initial begin
      req_n_o = 1'b1;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end

   task automatic req_ack(output bit ok);
      int n;
      ok = 1'b0;
      @(posedge mclk_i) req_n_o <= 1'b0;
      for (n = 0; n < 60 && !ok; n++) begin
         @(posedge mclk_i);
         ok = (dso_i === 1'b0);
      end
      req_n_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
   endtask

   // ten processor cycles a bit, msb first
   task automatic xfer(input logic [23:0] w, output logic [23:0] r);
      int i;
      @(posedge mclk_i);
      for (i = 23; i >= 0; i--) begin
         sdi_o <= w[i];
         sck_o <= 1'b1;
         repeat (5) @(posedge mclk_i);
         r[i] = dso_i; // output launched on the rise, settled by now
         sck_o <= 1'b0;
         repeat (5) @(posedge mclk_i);
      end
      sdi_o <= 1'b0;
   endtask
endmodule // dre_ctrl_model

/* test/dre_entry_bench.sv */
// self-checking bench for the debug request entry block
// assumes the controller model drives the pins; the bench plays the core
`timescale 1ns/1ps

// ==========
// bench
module dre_entry_bench;
   import dre_pkg::*;
   logic        mclk_i, sys_rst_i, debug_request_n_i, debug_serial_clock_i;
   logic        debug_serial_in_i, core_instr_done_i, core_low_power_i, cmd_ack_i;
   logic        exit_debug_i, tx_load_i, core_halt_o, core_wake_o, debug_mode_o;
   logic        port_reset_o, rx_valid_o, tx_busy_o, debug_serial_out_o;
   logic [23:0] pipe_state_i, tx_word_i, pipe_saved_o, rx_word_o, r;
   dre_state_t  state_o;
   int          n_rx, n_prst, n_wake, cyc, err_total, checks_done;
   bit          ok;

   dre_entry dut (.mclk_i, .sys_rst_i, .debug_request_n_i, .debug_serial_clock_i,
      .debug_serial_in_i, .core_instr_done_i, .core_low_power_i, .pipe_state_i, .cmd_ack_i,
      .exit_debug_i, .tx_load_i, .tx_word_i, .core_halt_o, .core_wake_o, .state_o,
      .debug_mode_o, .pipe_saved_o, .port_reset_o, .rx_word_o, .rx_valid_o, .tx_busy_o,
      .debug_serial_out_o);
   dre_ctrl_model u_ctl (.mclk_i, .dso_i(debug_serial_out_o), .req_n_o(debug_request_n_i),
      .sck_o(debug_serial_clock_i), .sdi_o(debug_serial_in_i));

   always #4 mclk_i = ~mclk_i;

   // pulse counters, since pulses pass while the model is busy
   always @(posedge mclk_i) begin
      n_rx += (rx_valid_o === 1'b1);
      n_prst += (port_reset_o === 1'b1);
      n_wake += (core_wake_o === 1'b1);
      if (++cyc == 6000) begin
         err_total++;
         conclude();
      end
   end

   task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
      checks_done++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic pulse_done();
      @(posedge mclk_i) core_instr_done_i <= 1'b1;
      @(posedge mclk_i) core_instr_done_i <= 1'b0;
   endtask

   // halt, finish the instruction, save pipeline, acknowledge
   task automatic t_entry();
      pipe_state_i <= 24'h5a3c81;
      fork
         u_ctl.req_ack(ok);
         begin
            repeat (6) @(posedge mclk_i);
            chk("halt", 24'h1, core_halt_o);
            pulse_done();
         end
      join
      chk("ack", 24'h1, ok);
      chk("state", 24'(DRE_DEBUG), 24'(state_o));
      chk("debug mode", 24'h1, debug_mode_o);
      chk("pipe", 24'h5a3c81, pipe_saved_o);
   endtask

   // full duplex word, then a command acknowledge of two cycles
   task automatic t_shift();
      int n;
      @(posedge mclk_i) tx_load_i <= 1'b1;
      tx_word_i <= 24'hc3a5e7;
      @(posedge mclk_i) tx_load_i <= 1'b0;
      u_ctl.xfer(24'ha5c3e1, r);
      chk("tx word", 24'hc3a5e7, r);
      chk("rx word", 24'ha5c3e1, rx_word_o);
      chk("rx count", 24'h1, 24'(n_rx));
      chk("busy", 24'h0, tx_busy_o);
      @(posedge mclk_i) cmd_ack_i <= 1'b1;
      @(posedge mclk_i) cmd_ack_i <= 1'b0;
      for (n = 0; n < 6; n++) begin
         @(posedge mclk_i);
         r[n] = debug_serial_out_o;
      end
      chk("cmd ack low", 24'h2, 24'(6 - $countones(r[5:0])));
   endtask

   // request inside debug resets the port and returns to debug
   task automatic t_prst();
      u_ctl.req_ack(ok);
      chk("prst ack", 24'h1, ok);
      chk("prst count", 24'h1, 24'(n_prst));
      chk("prst state", 24'(DRE_DEBUG), 24'(state_o));
      @(posedge mclk_i) exit_debug_i <= 1'b1;
      @(posedge mclk_i) exit_debug_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      chk("exit state", 24'(DRE_RUN), 24'(state_o));
      chk("exit mode", 24'h0, debug_mode_o);
      chk("halt off", 24'h0, core_halt_o);
      u_ctl.xfer(24'hffffff, r); // ignored outside debug
      chk("rx refused", 24'h1, 24'(n_rx));
   endtask

   // request in wait or stop wakes the core straight into debug
   task automatic t_wake();
      core_low_power_i <= 1'b1;
      pipe_state_i <= 24'h3c5a96;
      u_ctl.req_ack(ok);
      core_low_power_i <= 1'b0;
      chk("wake ack", 24'h1, ok);
      chk("wake count", 24'h1, 24'(n_wake));
      chk("wake state", 24'(DRE_DEBUG), 24'(state_o));
      chk("wake pipe", 24'h3c5a96, pipe_saved_o);
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      {mclk_i, core_instr_done_i, core_low_power_i, cmd_ack_i} = 4'h0;
      {exit_debug_i, tx_load_i, pipe_state_i, tx_word_i} = 50'h0;
      {n_rx, n_prst, n_wake, cyc, err_total, checks_done} = '0;
      sys_rst_i = 1'b1;
      repeat (8) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      chk("idle out", 24'h1, debug_serial_out_o);
      t_entry();
      t_shift();
      t_prst();
      t_wake();
      conclude();
   end
endmodule // dre_entry_bench
